// *** rtl/iocps_pkg.sv ***
/*
  Constants, state encoding and condition codes of the channel
  poll and start sequencer.
  Assumes a 100 MHz channel clock and 64-bit storage words.
*/
package iocps_pkg;
  localparam real CLK_NS       = 10.0;
  localparam real POLL_HOLD_NS = 2.2;
  localparam real SEL_DLY_NS   = 400.0;
  localparam int  POLL_RAW     = int'($ceil(POLL_HOLD_NS / CLK_NS));
  localparam int  POLL_HOLD_CYC = (POLL_RAW < 1) ? 1 : POLL_RAW;
  localparam int  SEL_DLY_CYC  = int'($ceil(SEL_DLY_NS / CLK_NS));
  localparam int  SBO_DLY_CYC  = 2;

  localparam logic [23:0] CAW_LOC = 24'h000048;
  localparam logic [23:0] CSW_LOC = 24'h000040;
  localparam logic [23:0] DW_INC  = 24'h000008;

  // storage word field positions (lsb of each field)
  localparam int CAW_KEY_LSB  = 60;
  localparam int CAW_RSV_LSB  = 56;
  localparam int CAW_ADR_LSB  = 32;
  localparam int CCW_CMD_LSB  = 56;
  localparam int CCW_ADR_LSB  = 32;
  localparam int CCW_FLG_LSB  = 27;
  localparam int CCW_CNT_LSB  = 0;

  // channel status bits
  localparam int CST_PROG = 5;
  localparam int CST_CDAT = 3;
  localparam int CST_IFCC = 1;

  // condition codes
  localparam logic [1:0] CC_AVAIL    = 2'h0;
  localparam logic [1:0] CC_STORED   = 2'h1;
  localparam logic [1:0] CC_WORKING  = 2'h2;
  localparam logic [1:0] CC_UNAVAIL  = 2'h3;
  localparam logic [1:0] CC_HIO_PEND = 2'h0;
  localparam logic [1:0] CC_HIO_HALT = 2'h2;
  localparam logic [1:0] CC_TCH_RDY  = 2'h1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, ST_PL_UP = 4'h1, ST_PL_HLD = 4'h3, ST_PR_STA = 4'h2,
    ST_PR_STK = 4'h6, ST_CAW_RQ = 4'h7, ST_CAW_WT = 4'h5, ST_CAW_DL = 4'h4,
    ST_RUN   = 4'hc, ST_CMD   = 4'hd, ST_ACCEPT = 4'hf, ST_CSW_RQ = 4'he,
    ST_CSW_WT = 4'ha
  } iocps_state_type;
endpackage : iocps_pkg

// *** rtl/iocps_timer.sv ***
/*
  Down-counting single-shot timer for the channel sequencer.
  Assumes loads come from the sequencer on the same clock.
*/
`timescale 1ns/100ps
module iocps_timer #(
  parameter int W = 8
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } iocps_tmr_type;

  iocps_tmr_type r;
  iocps_tmr_type next_r;

  // load or count down to zero
  always_comb begin
    next_r = r;
    if (load_in) begin
      next_r.cnt = count_in;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_out = (r.cnt == '0) && !load_in;
endmodule : iocps_timer

// *** rtl/iocps_channel.sv ***
/*
  Channel sequencer: idle polling of control units, condition codes
  with release, and the start I/O initial selection sequence.
  Assumes all inputs synchronous to mclk_in and a storage controller
  that answers requests with response and advance pulses.
*/
`timescale 1ns/100ps
module iocps_channel #(
  parameter int TW      = 8,
  parameter int SBO_DLY = iocps_pkg::SBO_DLY_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        select_channel_in,
  input  wire logic        start_io_in,
  input  wire logic        test_chan_in,
  input  wire logic [7:0]  unit_addr_in,
  input  wire logic        unit_addr_par_in,
  input  wire logic        int_accept_in,
  input  wire logic        logout_in,
  output logic             release_out,
  output logic [1:0]       cond_code_out,
  output logic             int_req_out,
  output logic             int_done_out,
  output logic [7:0]       int_unit_addr_out,
  output logic [7:0]       int_status_out,
  output logic             select_out_out,
  input  wire logic        select_in_in,
  input  wire logic        op_in_in,
  input  wire logic        addr_in_in,
  input  wire logic        status_in_in,
  input  wire logic [7:0]  bus_in_in,
  output logic [7:0]       bus_out_out,
  output logic             addr_out_out,
  output logic             cmd_out_out,
  output logic             service_out_out,
  output logic             stack_out_out,
  output logic             stor_req_out,
  input  wire logic        bcu_resp_in,
  input  wire logic        bcu_adv_in,
  output logic [23:0]      sab_out,
  output logic             stor_store_out,
  output logic [3:0]       stor_key_out,
  output logic [63:0]      stor_data_out,
  input  wire logic [63:0] sbo_in,
  input  wire logic [7:0]  sbo_par_in,
  output logic             ccw_valid_out,
  output logic [23:0]      cmd_addr_out,
  output logic [23:0]      data_addr_out,
  output logic [4:0]       flags_out,
  output logic [15:0]      count_out
);
  typedef struct packed {
    iocps_pkg::iocps_state_type st;
    logic        selo;
    logic        addro;
    logic        cmdo;
    logic        svco;
    logic        stko;
    logic        sreq;
    logic        store;
    logic [7:0]  busout;
    logic [23:0] storage_address_bus;
    logic        rel;
    logic [1:0]  cc;
    logic        intr;
    logic        idone;
    logic [7:0]  uaddr;
    logic [7:0]  ustat;
    logic        eprog;
    logic        epar;
    logic        eifcc;
    logic        unav;
    logic        resel;
    logic        cpend;
    logic        ccwv;
    logic [1:0]  fph;
    logic [1:0]  sph;
    logic [2:0]  dly;
    logic [3:0]  key;
    logic [23:0] daddr;
    logic [23:0] cinc;
    logic [23:0] caddr;
    logic [7:0]  cmd;
    logic [4:0]  flags;
    logic [15:0] cnt;
  } iocps_chan_type;

  iocps_chan_type r;
  iocps_chan_type next_r;
  logic           tload;
  logic [TW-1:0]  tcount;
  logic           tdone;
  logic           start;
  logic           can_start;
  logic           err;
  logic [7:0]     par_ok;
  logic [7:0]     cstat;

  // single-shot and address-to-select delay timer
  iocps_timer #(.W(TW)) u_tmr (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (tload),
    .count_in   (tcount),
    .done_out   (tdone)
  );

  // odd parity per storage byte
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_par
      assign par_ok[gi] = ^{sbo_in[8*gi +: 8], sbo_par_in[gi]};
    end
  endgenerate

  assign start = select_channel_in && start_io_in;
  assign err   = r.eprog || r.epar || r.eifcc;
  assign can_start = !r.intr && (r.st == iocps_pkg::ST_IDLE ||
                     r.st == iocps_pkg::ST_PL_HLD ||
                     (r.st == iocps_pkg::ST_PL_UP && !op_in_in));

  // sequencer next state
  always_comb begin
    next_r = r;
    next_r.rel = 1'b0;
    next_r.idone = 1'b0;
    tload = 1'b0;
    tcount = TW'(iocps_pkg::SEL_DLY_CYC);
    if (select_channel_in && test_chan_in) begin
      next_r.rel = 1'b1;
      next_r.cc = r.intr ? iocps_pkg::CC_TCH_RDY :
                  (can_start ? iocps_pkg::CC_AVAIL : iocps_pkg::CC_WORKING);
    end
    if (start && !can_start) begin
      next_r.rel = 1'b1;
      next_r.cc = iocps_pkg::CC_WORKING;
    end else if (start) begin
      next_r.uaddr = unit_addr_in;
      next_r.eprog = ~^{unit_addr_in, unit_addr_par_in};
      next_r.epar = 1'b0;
      next_r.eifcc = 1'b0;
      next_r.unav = 1'b0;
      next_r.resel = 1'b0;
      next_r.ccwv = 1'b0;
      next_r.selo = 1'b0;
      next_r.sreq = 1'b1;
      next_r.st = iocps_pkg::ST_CAW_RQ;
    end else begin
      case (r.st)
        iocps_pkg::ST_IDLE: begin
          if (r.intr && int_accept_in) begin
            next_r.resel = 1'b1;
            next_r.fph = 2'h3;
            next_r.sph = 2'h0;
            next_r.addro = 1'b1;
            next_r.busout = r.uaddr;
            tload = 1'b1;
            next_r.st = iocps_pkg::ST_RUN;
          end else if (!r.intr && !logout_in) begin
            next_r.selo = 1'b1;
            next_r.st = iocps_pkg::ST_PL_UP;
          end
        end
        iocps_pkg::ST_PL_UP: begin
          if (op_in_in && addr_in_in) begin
            next_r.uaddr = bus_in_in;
            next_r.selo = 1'b0;
            next_r.cmdo = 1'b1;
            next_r.st = iocps_pkg::ST_PR_STA;
          end else if (select_in_in) begin
            next_r.selo = 1'b0;
            tload = 1'b1;
            tcount = TW'(iocps_pkg::POLL_HOLD_CYC);
            next_r.st = iocps_pkg::ST_PL_HLD;
          end
        end
        iocps_pkg::ST_PL_HLD: begin
          if (tdone) begin
            next_r.st = iocps_pkg::ST_IDLE;
          end
        end
        iocps_pkg::ST_PR_STA: begin
          if (status_in_in) begin
            next_r.cmdo = 1'b0;
            next_r.stko = 1'b1;
            next_r.st = iocps_pkg::ST_PR_STK;
          end
        end
        iocps_pkg::ST_PR_STK: begin
          if (!status_in_in) begin
            next_r.stko = 1'b0;
          end
          if (!status_in_in && !op_in_in) begin
            next_r.intr = 1'b1;
            next_r.st = iocps_pkg::ST_IDLE;
          end
        end
        iocps_pkg::ST_CAW_RQ: begin
          if (bcu_resp_in) begin
            next_r.sreq = 1'b0;
            next_r.storage_address_bus = iocps_pkg::CAW_LOC;
            next_r.st = iocps_pkg::ST_CAW_WT;
          end
        end
        iocps_pkg::ST_CAW_WT: begin
          if (bcu_adv_in) begin
            next_r.dly = 3'(SBO_DLY);
            next_r.st = iocps_pkg::ST_CAW_DL;
          end
        end
        iocps_pkg::ST_CAW_DL: begin
          if (r.dly != 3'h0) begin
            next_r.dly = r.dly - 3'h1;
          end else begin
            next_r.key = sbo_in[iocps_pkg::CAW_KEY_LSB +: 4];
            next_r.daddr = sbo_in[iocps_pkg::CAW_ADR_LSB +: 24];
            if (r.eprog || sbo_in[iocps_pkg::CAW_RSV_LSB +: 4] != 4'h0 ||
                sbo_in[iocps_pkg::CAW_ADR_LSB +: 3] != 3'h0) begin
              next_r.eprog = 1'b1;
              next_r.sreq = 1'b1;
              next_r.st = iocps_pkg::ST_CSW_RQ;
            end else begin
              next_r.fph = 2'h0;
              next_r.sph = 2'h0;
              next_r.sreq = 1'b1;
              next_r.addro = 1'b1;
              next_r.busout = r.uaddr;
              tload = 1'b1;
              next_r.st = iocps_pkg::ST_RUN;
            end
          end
        end
        iocps_pkg::ST_RUN: begin
          // command word fetch half
          case (r.fph)
            2'h0: if (bcu_resp_in) begin
              next_r.sreq = 1'b0;
              next_r.storage_address_bus = r.daddr;
              next_r.cinc = r.daddr + iocps_pkg::DW_INC;
              next_r.fph = 2'h1;
            end
            2'h1: if (bcu_adv_in) begin
              next_r.dly = 3'(SBO_DLY);
              next_r.fph = 2'h2;
            end
            2'h2: begin
              if (r.dly != 3'h0) begin
                next_r.dly = r.dly - 3'h1;
              end else begin
                next_r.cmd = sbo_in[iocps_pkg::CCW_CMD_LSB +: 8];
                next_r.daddr = sbo_in[iocps_pkg::CCW_ADR_LSB +: 24];
                next_r.flags = sbo_in[iocps_pkg::CCW_FLG_LSB +: 5];
                next_r.cnt = sbo_in[iocps_pkg::CCW_CNT_LSB +: 16];
                if (par_ok != 8'hff) begin
                  next_r.epar = 1'b1;
                end else if (sbo_in[iocps_pkg::CCW_CMD_LSB +: 4] == 4'h0 ||
                             sbo_in[iocps_pkg::CCW_CNT_LSB +: 16] == 16'h0) begin
                  next_r.eprog = 1'b1;
                end else begin
                  next_r.ccwv = 1'b1;
                  next_r.caddr = r.cinc;
                end
                next_r.fph = 2'h3;
              end
            end
            default: ;
          endcase
          // device selection half
          case (r.sph)
            2'h0: if (tdone) begin
              next_r.selo = 1'b1;
              next_r.sph = 2'h1;
            end
            2'h1: if (op_in_in) begin
              next_r.addro = 1'b0;
              next_r.sph = 2'h2;
            end else if (select_in_in) begin
              next_r.selo = 1'b0;
              next_r.addro = 1'b0;
              next_r.unav = 1'b1;
              next_r.sph = 2'h3;
            end
            2'h2: if (addr_in_in) begin
              next_r.eifcc = (bus_in_in != r.uaddr);
              next_r.sph = 2'h3;
            end
            default: ;
          endcase
          // both halves met
          if (r.fph == 2'h3 && r.sph == 2'h3) begin
            if (r.unav) begin
              next_r.rel = 1'b1;
              next_r.cc = iocps_pkg::CC_UNAVAIL;
              next_r.busout = 8'h00;
              next_r.resel = 1'b0;
              next_r.st = iocps_pkg::ST_IDLE;
            end else begin
              next_r.cmdo = 1'b1;
              next_r.busout = (r.resel || err) ? 8'h00 : r.cmd;
              next_r.st = iocps_pkg::ST_CMD;
            end
          end
        end
        iocps_pkg::ST_CMD: begin
          if (status_in_in) begin
            next_r.cmdo = 1'b0;
            next_r.selo = 1'b0;
            next_r.svco = 1'b1;
            next_r.ustat = bus_in_in;
            next_r.cpend = 1'b1;
            next_r.st = iocps_pkg::ST_ACCEPT;
            if (r.resel) begin
              next_r.idone = 1'b1;
              next_r.intr = 1'b0;
              next_r.cpend = 1'b0;
            end else if (!err && bus_in_in == 8'h00) begin
              next_r.rel = 1'b1;
              next_r.cc = iocps_pkg::CC_AVAIL;
              next_r.cpend = 1'b0;
            end
          end
        end
        iocps_pkg::ST_ACCEPT: begin
          if (!status_in_in) begin
            next_r.svco = 1'b0;
          end
          if (!status_in_in && !op_in_in) begin
            next_r.busout = 8'h00;
            next_r.resel = 1'b0;
            next_r.sreq = r.cpend;
            next_r.st = r.cpend ? iocps_pkg::ST_CSW_RQ : iocps_pkg::ST_IDLE;
          end
        end
        iocps_pkg::ST_CSW_RQ: begin
          if (bcu_resp_in) begin
            next_r.sreq = 1'b0;
            next_r.storage_address_bus = iocps_pkg::CSW_LOC;
            next_r.store = 1'b1;
            next_r.st = iocps_pkg::ST_CSW_WT;
          end
        end
        iocps_pkg::ST_CSW_WT: begin
          if (bcu_adv_in) begin
            next_r.store = 1'b0;
            next_r.rel = 1'b1;
            next_r.cc = iocps_pkg::CC_STORED;
            next_r.cpend = 1'b0;
            next_r.st = iocps_pkg::ST_IDLE;
          end
        end
        default: next_r.st = iocps_pkg::ST_IDLE;
      endcase
    end
  end

  // state register, cleared by synchronous reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // channel status byte from the error latches
  always_comb begin
    cstat = 8'h00;
    cstat[iocps_pkg::CST_PROG] = r.eprog;
    cstat[iocps_pkg::CST_CDAT] = r.epar;
    cstat[iocps_pkg::CST_IFCC] = r.eifcc;
  end

  // outputs
  assign release_out       = r.rel;
  assign cond_code_out     = r.cc;
  assign int_req_out       = r.intr;
  assign int_done_out      = r.idone;
  assign int_unit_addr_out = r.uaddr;
  assign int_status_out    = r.ustat;
  assign select_out_out    = r.selo;
  assign bus_out_out       = r.busout;
  assign addr_out_out      = r.addro;
  assign cmd_out_out       = r.cmdo;
  assign service_out_out   = r.svco;
  assign stack_out_out     = r.stko;
  assign stor_req_out      = r.sreq;
  assign sab_out           = r.storage_address_bus;
  assign stor_store_out    = r.store;
  assign stor_key_out      = r.key;
  assign stor_data_out     = {r.key, 4'h0, r.caddr, r.ustat, cstat, r.cnt};
  assign ccw_valid_out     = r.ccwv;
  assign cmd_addr_out      = r.caddr;
  assign data_addr_out     = r.daddr;
  assign flags_out         = r.flags;
  assign count_out         = r.cnt;

  // helper: cycles address out has stood
  logic [7:0] acnt;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !r.addro) begin
      acnt <= 8'h00;
    end else if (acnt != 8'hff) begin
      acnt <= acnt + 8'h01;
    end
  end

  localparam int SEL_MIN = iocps_pkg::SEL_DLY_CYC;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  a_poll_gate: assert property ($rose(r.st == iocps_pkg::ST_PL_UP) |->
    $past(!r.intr && !logout_in)) else $error("poll started while blocked");
  a_poll_hold: assert property (r.st == iocps_pkg::ST_PL_UP && select_in_in &&
    !op_in_in && !start |=> !select_out_out ##1 !select_out_out)
    else $error("select out not held low after select in");
  a_int_block: assert property (int_req_out |-> r.st != iocps_pkg::ST_PL_UP)
    else $error("polling while interrupt request stands");
  a_stack_int: assert property (r.st == iocps_pkg::ST_PR_STK && !status_in_in &&
    !op_in_in && !start |=> int_req_out) else $error("no interrupt after stacking");
  a_busy_code: assert property (start && !can_start |=>
    release_out && cond_code_out == 2'h2) else $error("busy start not given code 2");
  a_sel_delay: assert property ($rose(select_out_out) && addr_out_out |->
    acnt >= SEL_MIN) else $error("select out too soon after address out");
  a_caw_addr: assert property (r.st == iocps_pkg::ST_CAW_WT |->
    sab_out == 24'h000048) else $error("address word not at location 72");
  a_cmd_incr: assert property ($rose(ccw_valid_out) |->
    cmd_addr_out == $past(r.daddr) + 24'h000008) else $error("command address wrong");
  a_zero_stat: assert property (r.st == iocps_pkg::ST_CMD && status_in_in &&
    bus_in_in == 8'h00 && !err && !r.resel && !start |=> release_out &&
    cond_code_out == 2'h0) else $error("zero status not given code 0");
  a_rst_clear: assert property (disable iff (1'b0) sys_rst_in |=>
    !int_req_out && !ccw_valid_out && !select_out_out) else $error("reset left state");
endmodule : iocps_channel

// *** verification/iocps_partner.sv ***
/*
  One control unit on the select loop and a fixed-latency storage controller.
  Assumes the channel and the bench drive every input on the same clock; lines that are
  released show a changing pattern.
*/
`timescale 1ns/100ps
module iocps_partner (
  input  wire logic        clk_in,
  input  wire logic        sel_in,
  input  wire logic        adr_in,
  input  wire logic        cmd_in,
  input  wire logic        fin_in,
  input  wire logic        req_in,
  input  wire logic [23:0] sab_in,
  input  wire logic        pend_in,
  input  wire logic        absent_in,
  input  wire logic [7:0]  ua_in,
  input  wire logic [7:0]  stat_in,
  input  wire logic [63:0] caw_in,
  input  wire logic [63:0] ccw_in,
  output logic             sel_ret_out,
  output logic             op_out,
  output logic             ain_out,
  output logic             sin_out,
  output logic [7:0]       bus_out,
  output logic             resp_out,
  output logic             adv_out,
  output logic [63:0]      sbo_out,
  output logic [7:0]       par_out
);
  logic [3:0] cnt;
  initial {cnt, sel_ret_out, op_out, ain_out, sin_out, bus_out, resp_out, adv_out, sbo_out} = '0;
  // unit: pass select on when quiet, else block it and answer
  always @(posedge clk_in) begin
    // an absent unit passes select straight back and never answers
    sel_ret_out <= sel_in & (absent_in | (~adr_in & ~pend_in & ~op_out));
    if (fin_in | (sin_out & ~cmd_in)) op_out <= 1'b0;
    else if (sel_in & ~absent_in & (adr_in | pend_in)) op_out <= 1'b1;
    ain_out <= op_out & ~adr_in & ~cmd_in & ~sin_out & ~fin_in;
    sin_out <= op_out & (cmd_in | sin_out) & ~fin_in;
    if (op_out & (cmd_in | sin_out) & ~fin_in) bus_out <= stat_in;
    else if (op_out & ~adr_in & ~cmd_in & ~fin_in) bus_out <= ua_in;
    else bus_out <= ~bus_out;
  end
  // storage: response, then advance, word held a few cycles
  always @(posedge clk_in) begin
    resp_out <= (cnt == 4'h1);
    adv_out <= (cnt == 4'h3);
    if (cnt == 4'h3) sbo_out <= (sab_in == 24'h000048) ? caw_in : ccw_in;
    else if (cnt == 4'h9) sbo_out <= ~sbo_out;
    cnt <= (cnt == 4'h9) ? 4'h0 : (cnt != 4'h0) ? cnt + 4'h1 : {3'h0, req_in};
  end
  // odd parity per byte
  always_comb for (int i = 0; i < 8; i++) par_out[i] = ~^sbo_out[8*i +: 8];
endmodule : iocps_partner

// *** verification/iocps_channel_tb.sv ***
/*
  Self-checking bench of the channel sequencer: polling, start paths,
  polled interrupt. Assumes the partner model on the far side.
*/
`timescale 1ns/100ps
module iocps_channel_tb;
  logic        mclk_in = 1'b0, sys_rst_in = 1'b1, sel_ch = 1'b0, sio = 1'b0, tch = 1'b0;
  logic        acc = 1'b0, pend = 1'b0, pbad = 1'b0, stored = 1'b0, absent = 1'b0;
  logic [4:0]  flg;
  logic [7:0]  ua = 8'h5a, stat = 8'h00;
  logic [63:0] channel_address_word = 64'h0, channel_command_word = 64'h0;
  logic        rel, ireq, idone, so, si, op, ain, sin, ao, co, sv, sk, req, resp, adv, st, cval;
  logic [1:0]  cc;
  logic [7:0]  iua, ist, bin, bout, par;
  logic [23:0] storage_address_bus, cadr, dadr;
  logic [63:0] storage_bus_out;
  logic [3:0]  key;
  logic [15:0] cnt;
  int          mismatches = 0, checks = 0, cyc = 0, gap = 0, gap_at_sel = 0;

  iocps_channel uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .select_channel_in(sel_ch),
    .start_io_in(sio), .test_chan_in(tch), .unit_addr_in(ua), .unit_addr_par_in(~^ua ^ pbad),
    .int_accept_in(acc), .logout_in(1'b0), .release_out(rel), .cond_code_out(cc),
    .int_req_out(ireq), .int_done_out(idone), .int_unit_addr_out(iua), .int_status_out(ist),
    .select_out_out(so), .select_in_in(si), .op_in_in(op), .addr_in_in(ain),
    .status_in_in(sin), .bus_in_in(bin), .bus_out_out(bout), .addr_out_out(ao),
    .cmd_out_out(co), .service_out_out(sv), .stack_out_out(sk), .stor_req_out(req),
    .bcu_resp_in(resp), .bcu_adv_in(adv), .sab_out(storage_address_bus), .stor_store_out(st),
    .stor_key_out(key), .stor_data_out(), .sbo_in(storage_bus_out), .sbo_par_in(par),
    .ccw_valid_out(cval), .cmd_addr_out(cadr), .data_addr_out(dadr), .flags_out(flg),
    .count_out(cnt));
  iocps_partner far (.clk_in(mclk_in), .sel_in(so), .adr_in(ao), .cmd_in(co), .fin_in(sv | sk),
    .req_in(req), .sab_in(storage_address_bus), .pend_in(pend), .absent_in(absent), .ua_in(ua),
    .stat_in(stat), .caw_in(channel_address_word),
    .ccw_in(channel_command_word), .sel_ret_out(si), .op_out(op), .ain_out(ain), .sin_out(sin), .bus_out(bin),
    .resp_out(resp), .adv_out(adv), .sbo_out(storage_bus_out), .par_out(par));

  always #5 mclk_in = ~mclk_in;
  // cycle ceiling, address-to-select gap, status store seen
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (st) stored <= 1'b1;
    if (ao & ~so) gap <= gap + 1;
    else begin
      if (ao & so & gap != 0) gap_at_sel <= gap;
      gap <= 0;
    end
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic step;
    @(posedge mclk_in);
    #1;
  endtask : step
  // one instruction, then wait for its release
  task automatic issue(input logic s, input logic t);
    @(posedge mclk_in);
    {sel_ch, sio, tch} <= {1'b1, s, t};
    @(posedge mclk_in);
    {sel_ch, sio, tch} <= 3'h0;
    #1;
    stored = 1'b0;
    for (int i = 0; i < 900 && rel !== 1'b1; i++) step();
  endtask : issue

  task automatic t_reset;
    check(ireq, 0);
    check(cval, 0);
    check(so, 0);
    for (int i = 0; i < 3 && so !== 1'b1; i++) step();
    check(so, 1);
    issue(0, 1);
    check(cc, 0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_poll;
    for (int i = 0; i < 20 && si !== 1'b1; i++) step();
    step();
    check(so, 0);
    step();
    check(so, 0);
    for (int i = 0; i < 6 && so !== 1'b1; i++) step();
    check(so, 1);
    $display("t_poll done");
  endtask : t_poll
  task automatic t_start_ok;
    channel_address_word = 64'h3000100000000000;
    channel_command_word = 64'h0200200040000010;
    issue(1, 0);
    check(dadr, 24'h002000);
    check(flg, 5'h08);
    check(rel, 1);
    check(cc, 0);
    check(cval, 1);
    check(cadr, 24'h001008);
    check(key, 4'h3);
    check(cnt, 16'h0010);
    check(gap_at_sel >= 40, 1);
    step();
    check(rel, 0);
    repeat (10) step();
    $display("t_start_ok done");
  endtask : t_start_ok
  // device missing from the loop: channel itself is available, so code 3 comes from it
  task automatic t_unavail;
    absent = 1'b1;
    issue(1, 0);
    check(rel, 1);
    check(cc, 3);
    absent = 1'b0;
    repeat (10) step();
    $display("t_unavail done");
  endtask : t_unavail
  task automatic t_errors;
    for (int k = 0; k < 3; k++) begin
      channel_address_word = (k == 0) ? 64'h3100100000000000 : 64'h3000100000000000;
      channel_command_word = (k == 2) ? 64'h0200200000000000 : 64'h0200200000000010;
      pbad = (k == 1);
      issue(1, 0);
      check(cc, 1);
      check(stored, 1);
      if (k == 2) check(cval, 0);
      pbad = 1'b0;
      repeat (10) step();
    end
    $display("t_errors done");
  endtask : t_errors
  task automatic t_intr;
    stat = 8'h0c;
    pend <= 1'b1;
    for (int i = 0; i < 300 && ireq !== 1'b1; i++) step();
    check(ireq, 1);
    check(iua, ua);
    repeat (20) step();
    check(so, 0);
    issue(1, 0);
    check(cc, 2);
    issue(0, 1);
    check(cc, 1);
    @(posedge mclk_in);
    acc <= 1'b1;
    @(posedge mclk_in);
    acc <= 1'b0;
    #1;
    for (int i = 0; i < 300 && idone !== 1'b1; i++) step();
    check(ist, stat);
    @(posedge mclk_in);
    pend <= 1'b0;
    #1;
    check(ireq, 0);
    for (int i = 0; i < 60 && so !== 1'b1; i++) step();
    check(so, 1);
    $display("t_intr done");
  endtask : t_intr

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    #1;
    t_reset();
    t_poll();
    t_start_ok();
    t_unavail();
    t_errors();
    t_intr();
    complete_run();
  end
endmodule : iocps_channel_tb
